// ==== rtl/iad_decoder.sv ====
// Internal area address decoder: latches the one-time data area mapping
// and classifies every CPU address into SFR, RAM, ROM, external space or no target.
// Assumes requests are synchronous to sys_clk and the CPU core issues the
// mapping-selection instruction once after reset.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module iad_decoder (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              rom64,
  input  wire logic              ext_en,
  input  wire logic              map_sel_stb,
  input  wire logic [3:0]        map_sel_code,
  input  wire iad_pkg::iad_req_s req,
  output iad_pkg::iad_dec_s      dec,
  output logic                   map_done,
  output logic                   map_high
);

  ////////////////////////////////////////////////////////////////////////
  // Mapping selection latch
  iad_pkg::iad_map_e map_q;
  iad_pkg::iad_map_e map_d;

  // First selection wins, any code but MAP_CODE_HIGH taking low; afterwards frozen until reset
  always_comb begin
    map_d = map_q;
    unique case (map_q)
      iad_pkg::IAD_MAP_NONE: begin
        if (map_sel_stb && map_sel_code == iad_pkg::MAP_CODE_HIGH) begin
          map_d = iad_pkg::IAD_MAP_HIGH;
        end else if (map_sel_stb) begin
          map_d = iad_pkg::IAD_MAP_LOW;
        end
      end
      iad_pkg::IAD_MAP_LOW:  map_d = map_q;
      iad_pkg::IAD_MAP_HIGH: map_d = map_q;
      default:               map_d = iad_pkg::IAD_MAP_NONE;
    endcase
  end

  // Only reset clears the selection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      map_q <= iad_pkg::IAD_MAP_NONE;
    end else if (clk_en) begin
      map_q <= map_d;
    end
  end

  assign map_done = map_q != iad_pkg::IAD_MAP_NONE;
  assign map_high = map_q == iad_pkg::IAD_MAP_HIGH;

  ////////////////////////////////////////////////////////////////////////
  // Address classification
  iad_pkg::iad_tgt_e tgt;

  iad_region u_region (
    .addr   (req.addr),
    .map    (map_q),
    .rom64  (rom64),
    .ext_en (ext_en),
    .tgt    (tgt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registered decode result
  iad_pkg::iad_dec_s dec_q;
  iad_pkg::iad_dec_s dec_d;

  // Offset is the address within the selected 64K-aligned region
  always_comb begin
    dec_d        = dec_q;
    dec_d.valid  = req.valid;
    if (req.valid) begin
      dec_d.tgt    = tgt;
      dec_d.addr   = req.addr;
      dec_d.offset = req.addr[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_q <= '{valid: 1'b0, tgt: iad_pkg::IAD_TGT_NONE,
                 addr: 20'h00000, offset: 16'h0000};
    end else if (clk_en) begin
      dec_q <= dec_d;
    end
  end

  assign dec = dec_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic in_lo_data;
  logic in_hi_data;
  logic outside_rom;
  logic outside_data;

  // Rule windows, kept apart from the classifier
  assign in_lo_data   = req.addr >= iad_pkg::DATA_LO_BASE &&
                        req.addr <= iad_pkg::DATA_LO_TOP;
  assign in_hi_data   = req.addr >= iad_pkg::DATA_HI_BASE;
  assign outside_rom  = rom64 ? req.addr > iad_pkg::ROM64_TOP
                              : req.addr > iad_pkg::ROM48_TOP;
  assign outside_data = !((map_q == iad_pkg::IAD_MAP_LOW && in_lo_data) ||
                          (map_q == iad_pkg::IAD_MAP_HIGH && in_hi_data));

  // Selection strobe at an enabled edge with nothing latched yet
  sequence sel_taken_seq;
    clk_en && !map_done && map_sel_stb;
  endsequence

  // Enabled edge that carries an access
  sequence acc_taken_seq;
    clk_en && req.valid;
  endsequence

  // Enabled edge with the request line idle
  sequence acc_idle_seq;
    clk_en && !req.valid;
  endsequence

  map_frozen_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    map_done |=> map_done && $stable(map_q))
    else $error("mapping changed after selection");

  // Code is compared as it stood with the strobe, not a cycle later
  map_take_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sel_taken_seq |=> map_done &&
      (map_high == ($past(map_sel_code) == iad_pkg::MAP_CODE_HIGH)))
    else $error("selection not taken");

  no_map_data_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && !map_done)
      |=> !(dec.tgt inside {iad_pkg::IAD_TGT_RAM, iad_pkg::IAD_TGT_SFR}))
    else $error("data area before selection");

  hold_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !clk_en |=> $stable(map_q) && $stable(dec))
    else $error("state moved while disabled");

  lo_data_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && map_q == iad_pkg::IAD_MAP_LOW && in_lo_data)
      |=> dec.tgt inside {iad_pkg::IAD_TGT_RAM, iad_pkg::IAD_TGT_SFR})
    else $error("low data area missed");

  lo_sfr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && map_q == iad_pkg::IAD_MAP_LOW &&
     req.addr >= iad_pkg::SFR_LO_BASE && req.addr <= iad_pkg::DATA_LO_TOP)
      |=> dec.tgt == iad_pkg::IAD_TGT_SFR)
    else $error("low SFR missed");

  hi_sfr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && map_q == iad_pkg::IAD_MAP_HIGH &&
     req.addr >= iad_pkg::SFR_HI_BASE)
      |=> dec.tgt == iad_pkg::IAD_TGT_SFR)
    else $error("high SFR missed");

  hi_data_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && map_q == iad_pkg::IAD_MAP_HIGH && in_hi_data)
      |=> dec.tgt inside {iad_pkg::IAD_TGT_RAM, iad_pkg::IAD_TGT_SFR})
    else $error("high data area missed");

  rom64_hi_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && rom64 && map_q == iad_pkg::IAD_MAP_HIGH &&
     req.addr <= iad_pkg::ROM64_TOP) |=> dec.tgt == iad_pkg::IAD_TGT_ROM)
    else $error("full ROM missed");

  rom48_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && !rom64 && req.addr > iad_pkg::ROM48_TOP &&
     req.addr < iad_pkg::DATA_LO_BASE && !ext_en)
      |=> dec.tgt == iad_pkg::IAD_TGT_NONE)
    else $error("48K ROM overrun");

  rom64_lo_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && rom64 && map_q == iad_pkg::IAD_MAP_LOW &&
     req.addr > iad_pkg::ROM64_LO_TOP && req.addr <= iad_pkg::ROM64_TOP)
      |=> dec.tgt != iad_pkg::IAD_TGT_ROM)
    else $error("hidden ROM reached");

  // External only outside the variant's ROM and the placed data area
  ext_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    acc_taken_seq |=> (dec.tgt == iad_pkg::IAD_TGT_EXT) ==
      $past(ext_en && outside_rom && outside_data))
    else $error("external routing wrong");

  no_ext_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clk_en && req.valid && !ext_en) |=> dec.tgt != iad_pkg::IAD_TGT_EXT)
    else $error("external without expansion");

  addr_copy_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    acc_taken_seq |=> dec.valid && dec.addr == $past(req.addr) &&
      dec.offset == $past(req.addr[15:0]))
    else $error("address not carried");

  valid_pulse_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    acc_idle_seq |=> !dec.valid)
    else $error("valid without request");

endmodule // iad_decoder
`default_nettype wire

// ==== include/iad_pkg.sv ====
// Package for the internal area address decoder: address map constants,
// region codes and the decode carrier structs.
// Assumes a 20-bit flat CPU address space.
package iad_pkg;

  localparam int          ADDR_W        = 20;
  // Data area (SFRs plus internal RAM), low and high placements
  localparam logic [19:0] DATA_LO_BASE  = 20'h0f700;
  localparam logic [19:0] DATA_LO_TOP   = 20'h0ffff;
  localparam logic [19:0] DATA_HI_BASE  = 20'hff700;
  localparam logic [19:0] DATA_HI_TOP   = 20'hfffff;
  // Special function registers: top 256 bytes of the data area
  localparam logic [19:0] SFR_LO_BASE   = 20'h0ff00;
  localparam logic [19:0] SFR_HI_BASE   = 20'hfff00;
  // Internal ROM limits per variant
  localparam logic [19:0] ROM48_TOP     = 20'h0bfff;
  localparam logic [19:0] ROM64_TOP     = 20'h0ffff;
  localparam logic [19:0] ROM64_LO_TOP  = 20'h0f6ff;
  // Mapping-selection operand codes
  localparam logic [3:0]  MAP_CODE_LOW  = 4'h0;
  localparam logic [3:0]  MAP_CODE_HIGH = 4'hf;

  // Decoded target of an access, one-hot
  typedef enum logic [4:0] {
    IAD_TGT_NONE = 5'h01,
    IAD_TGT_ROM  = 5'h02,
    IAD_TGT_RAM  = 5'h04,
    IAD_TGT_SFR  = 5'h08,
    IAD_TGT_EXT  = 5'h10
  } iad_tgt_e;

  // Mapping state, one-hot
  typedef enum logic [2:0] {
    IAD_MAP_NONE = 3'h1,
    IAD_MAP_LOW  = 3'h2,
    IAD_MAP_HIGH = 3'h4
  } iad_map_e;

  // Access request from the CPU core
  typedef struct packed {
    logic              valid;
    logic [19:0]       addr;
  } iad_req_s;

  // Decode result towards the memories
  typedef struct packed {
    logic              valid;
    iad_tgt_e          tgt;
    logic [19:0]       addr;
    logic [15:0]       offset;
  } iad_dec_s;

endpackage : iad_pkg

// ==== rtl/iad_region.sv ====
// Combinational region classifier for one 20-bit address.
// Assumes the mapping state is already latched by the caller.
`timescale 1ns/1ns
`default_nettype none
module iad_region (
  input  wire logic [19:0]       addr,
  input  wire iad_pkg::iad_map_e map,
  input  wire logic              rom64,
  input  wire logic              ext_en,
  output iad_pkg::iad_tgt_e      tgt
);

  logic in_data;
  logic in_sfr;
  logic in_rom;

  // Data area and SFR windows follow the latched placement
  always_comb begin
    in_data = 1'b0;
    in_sfr  = 1'b0;
    unique case (map)
      iad_pkg::IAD_MAP_LOW: begin
        in_data = addr >= iad_pkg::DATA_LO_BASE;
        in_data = in_data && addr <= iad_pkg::DATA_LO_TOP;
        in_sfr  = in_data && addr >= iad_pkg::SFR_LO_BASE;
      end
      iad_pkg::IAD_MAP_HIGH: begin
        in_data = addr >= iad_pkg::DATA_HI_BASE;
        in_sfr  = addr >= iad_pkg::SFR_HI_BASE;
      end
      iad_pkg::IAD_MAP_NONE: begin
        in_data = 1'b0;
        in_sfr  = 1'b0;
      end
      default: begin
        in_data = 1'b0;
        in_sfr  = 1'b0;
      end
    endcase
  end

  // ROM window per variant; data area overrides the overlap
  always_comb begin
    if (rom64) begin
      in_rom = addr <= iad_pkg::ROM64_TOP;
    end else begin
      in_rom = addr <= iad_pkg::ROM48_TOP;
    end
  end

  // Priority: SFR, RAM, ROM, then external
  always_comb begin
    if (in_sfr) begin
      tgt = iad_pkg::IAD_TGT_SFR;
    end else if (in_data) begin
      tgt = iad_pkg::IAD_TGT_RAM;
    end else if (in_rom) begin
      tgt = iad_pkg::IAD_TGT_ROM;
    end else if (ext_en) begin
      tgt = iad_pkg::IAD_TGT_EXT;
    end else begin
      tgt = iad_pkg::IAD_TGT_NONE;
    end
  end

endmodule // iad_region
`default_nettype wire

// ==== dv/iad_cpu_model.sv ====
// CPU core stand-in: issues accesses and mapping selections.
// Assumes bench commands change just after the sys_clk rising edge.
`timescale 1ns/1ns
`default_nettype none
module iad_cpu_model (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         go,
  input  wire logic [19:0]  go_addr,
  input  wire logic         sel,
  input  wire logic [3:0]   sel_code,
  output iad_pkg::iad_req_s req,
  output logic              map_sel_stb,
  output logic [3:0]        map_sel_code
);
  // One access or selection per command; idle lines show no stale value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req          <= '0;
      map_sel_stb  <= 1'b0;
      map_sel_code <= 4'h0;
    end else begin
      req.valid    <= go;
      req.addr     <= go ? go_addr : ~req.addr;
      map_sel_stb  <= sel;
      map_sel_code <= sel ? sel_code : ~map_sel_code;
    end
  end
endmodule // iad_cpu_model
`default_nettype wire

// ==== dv/internal_area_address_decoder_tb.sv ====
// Self-checking bench for the internal area address decoder.
// Assumes the CPU model in iad_cpu_model and a 25 MHz sys_clk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
  err_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module internal_area_address_decoder_tb;
  logic              sys_clk, rst_b, clk_en, rom64, ext_en, go, sel;
  logic [19:0]       go_addr;
  logic [3:0]        sel_code, map_sel_code, code;
  logic              map_sel_stb, map_done, map_high;
  iad_pkg::iad_req_s req;
  iad_pkg::iad_dec_s dec;
  logic [31:0]       lfsr;
  logic [19:0]       corner [13];
  int                err_count, checked, map_st;

  iad_cpu_model cpu (.sys_clk(sys_clk), .rst_b(rst_b), .go(go),
    .go_addr(go_addr), .sel(sel), .sel_code(sel_code), .req(req),
    .map_sel_stb(map_sel_stb), .map_sel_code(map_sel_code));
  iad_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .rom64(rom64), .ext_en(ext_en), .map_sel_stb(map_sel_stb),
    .map_sel_code(map_sel_code), .req(req), .dec(dec),
    .map_done(map_done), .map_high(map_high));

  ////////////////////////////////////////////////////////////////////////////
  // Random source and expected target
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic iad_pkg::iad_tgt_e exp_tgt(input logic [19:0] a);
    if (map_st != 0 && a[19:16] == (map_st == 2 ? 4'hf : 4'h0)
        && a[15:0] >= 16'hf700)
      return a[15:8] == 8'hff ? iad_pkg::IAD_TGT_SFR : iad_pkg::IAD_TGT_RAM;
    if (a <= (rom64 ? 20'h0ffff : 20'h0bfff))
      return iad_pkg::IAD_TGT_ROM;
    return ext_en ? iad_pkg::IAD_TGT_EXT : iad_pkg::IAD_TGT_NONE;
  endfunction

  // One access through the CPU model, checked when dec lands
  task automatic access(input logic [19:0] a);
    @(posedge sys_clk);
    go      <= 1'b1;
    go_addr <= a;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(dec.valid, 1'b1, "valid")
    `CHK(dec.tgt, exp_tgt(a), "target")
    `CHK(dec.tgt, exp_tgt(a), "region")
    `CHK(dec.offset, a[15:0], "offset")
    `CHK(dec.addr, a, "address")
  endtask
  task automatic select(input logic [3:0] c);
    @(posedge sys_clk);
    sel      <= 1'b1;
    sel_code <= c;
    @(posedge sys_clk);
    sel <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Eight strap, expansion and mapping combinations, each after a reset
  initial begin
    {rst_b, rom64, ext_en, go, sel, clk_en} = 6'h01;
    go_addr = '0;
    sel_code = '0;
    lfsr = 32'h1215;
    corner = '{20'h00000, 20'h0bfff, 20'h0c000, 20'h0f6ff, 20'h0f700,
      20'h0feff, 20'h0ff00, 20'h0ffff, 20'h10000, 20'hff6ff, 20'hff700,
      20'hfff00, 20'hfffff};
    for (int cfg = 0; cfg < 8; cfg++) begin
      @(posedge sys_clk);
      rst_b  <= 1'b0;
      rom64  <= cfg[0];
      ext_en <= cfg[1];
      map_st = 0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      `CHK(map_done, 1'b0, "done after reset")
      foreach (corner[i]) access(corner[i]);
      @(posedge sys_clk) clk_en <= 1'b0;
      select(4'hf);
      `CHK(map_done, 1'b0, "frozen select")
      @(posedge sys_clk) clk_en <= 1'b1;
      lfsr = lfsr_next(lfsr);
      code = cfg[2] ? 4'hf : {1'b0, lfsr[2:0]};
      select(code);
      map_st = cfg[2] ? 2 : 1;
      `CHK(map_done, 1'b1, "done")
      `CHK(map_high, cfg[2], "high")
      select(cfg[2] ? 4'h0 : 4'hf);
      `CHK(map_high, cfg[2], "second select")
      foreach (corner[i]) access(corner[i]);
      repeat (40) begin
        lfsr = lfsr_next(lfsr);
        access({lfsr[20] ? (lfsr[21] ? 4'hf : 4'h0) : lfsr[19:16],
                lfsr[15:0]});
      end
      $display("config %0d done", cfg);
    end
    final_report;
  end
endmodule // internal_area_address_decoder_tb
`default_nettype wire
